// ===== bench/mem_ctrl_model.sv
// Purpose: Behavioural memory controller that issues commands to the mode block.
// Assumes: One command per call, launched just after a rising edge.
// Notes: Released address lines show the inverse of the requested address.
`timescale 1ns/1ps
`default_nettype none
module mem_ctrl_model #(
  parameter int WAIT_CYC = 2
) (
  // Clock
  input wire logic clk,
  // Device feedback
  input wire logic read_drive,
  input wire logic read_valid,
  // Command lines
  output logic [1:0] cmd,
  output logic [12:0] addr,
  output logic bank_sel_bit0,
  output logic bank_sel_bit1,
  output logic banks_idle
);
  initial
  begin
    cmd = cfg_pkg::CMD_OTHER;
    addr = 13'h0000;
    bank_sel_bit0 = 1'b0;
    bank_sel_bit1 = 1'b0;
    banks_idle = 1'b1;
  end
  task automatic issue(input logic [1:0] c, input logic [12:0] a, input logic bad_bank);
    @(posedge clk);
    cmd <= c;
    addr <= a & 13'h03FF;
    bank_sel_bit0 <= bad_bank;
    bank_sel_bit1 <= 1'b0;
    @(posedge clk);
    cmd <= cfg_pkg::CMD_OTHER;
    addr <= ~a;
    bank_sel_bit0 <= 1'b0;
    if (c == cfg_pkg::CMD_LOAD)
      repeat (WAIT_CYC) @(posedge clk);
  endtask
  task automatic read_at(output int d, output int v);
    d = 0;
    v = 0;
    @(posedge clk);
    cmd <= cfg_pkg::CMD_READ;
    for (int i = 1; i <= 6; i++)
    begin
      @(posedge clk);
      cmd <= cfg_pkg::CMD_OTHER;
      @(negedge clk);
      if (read_drive === 1'b1 && d == 0)
        d = i;
      if (read_valid === 1'b1 && v == 0)
        v = i;
    end
  endtask
endmodule
`default_nettype wire

// ===== bench/sdram_mode_register_setup_tb_top.sv
// Purpose: Self-checking bench for the mode configuration block.
// Assumes: Zero-wait APB slave; load effect one edge after the load edge.
// Notes: Table rows cover legal and reserved codes; odd cases follow.
`timescale 1ns/1ps
`default_nettype none
module sdram_mode_register_setup_tb_top;
  localparam int WAITS = 2;
  typedef struct packed {logic [12:0] w; logic [3:0] len; logic ord; logic [2:0] lat;
    logic wlo; logic [2:0] st;} row_t;
  logic clk, resetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] cmd;
  logic [12:0] addr;
  logic bs0, bs1, idle, ord, wbp, wlo, rdrv, rval, busy;
  logic [3:0] blen;
  logic [2:0] lat;
  int bad_count, checks_done, d, v, el;
  row_t rows [9] = '{'{13'h0020, 4'h1, 1'b0, 3'h2, 1'b1, 3'h0},
    '{13'h0029, 4'h2, 1'b1, 3'h2, 1'b0, 3'h0}, '{13'h003A, 4'h4, 1'b1, 3'h3, 1'b0, 3'h0},
    '{13'h0233, 4'h8, 1'b0, 3'h3, 1'b1, 3'h0}, '{13'h0028, 4'h1, 1'b0, 3'h2, 1'b1, 3'h0},
    '{13'h0027, 4'h0, 1'b0, 3'h2, 1'b0, 3'h0}, '{13'h0004, 4'h0, 1'b0, 3'h0, 1'b0, 3'h3},
    '{13'h002F, 4'h0, 1'b1, 3'h2, 1'b0, 3'h1},
    '{13'h01A3, 4'h8, 1'b0, 3'h2, 1'b0, 3'h4}};
  mode_cfg #(.WAIT_CYC(WAITS)) u_dut (.clk(clk), .resetn(resetn), .cmd(cmd), .addr(addr),
    .bank_sel_bit0(bs0), .bank_sel_bit1(bs1), .banks_idle(idle), .burst_len(blen),
    .burst_order(ord), .read_latency(lat), .write_burst_policy(wbp), .write_len_one(wlo),
    .read_drive(rdrv), .read_valid(rval), .load_busy(busy), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  mem_ctrl_model #(.WAIT_CYC(WAITS)) u_ctrl (.clk(clk), .read_drive(rdrv), .read_valid(rval),
    .cmd(cmd), .addr(addr), .bank_sel_bit0(bs0), .bank_sel_bit1(bs1), .banks_idle(idle));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dat);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for an answer that never comes.
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    #400000;
    bad_count++;
    conclude();
  end
  initial
  begin
    resetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    chk("reset len", 32'h0000_0001, blen);
    chk("reset lat", 32'h0000_0002, lat);
    foreach (rows[i])
    begin
      u_ctrl.issue(cfg_pkg::CMD_LOAD, rows[i].w, 1'b0);
      @(negedge clk);
      chk("len", rows[i].len, blen);
      chk("order", rows[i].ord, ord);
      chk("lat", rows[i].lat, lat);
      chk("wb", rows[i].w[9], wbp);
      chk("wlo", rows[i].wlo, wlo);
      apb(1'b0, cfg_pkg::OFS_MODE, 32'h0000_0000);
      chk("mode", rows[i].w, rd);
      apb(1'b0, cfg_pkg::OFS_STATUS, 32'h0000_0000);
      chk("status", rows[i].st, rd[4:0]);
      el = (rows[i].lat == cfg_pkg::LAT_3) ? 3 : 2;
      u_ctrl.read_at(d, v);
      chk("drive", el, d);
      chk("valid", el + 1, v);
    end
    u_ctrl.issue(cfg_pkg::CMD_LOAD, 13'h0029, 1'b1);
    u_ctrl.issue(cfg_pkg::CMD_WRITE, 13'h0011, 1'b0);
    @(negedge clk);
    chk("kept len", 32'h0000_0008, blen);
    apb(1'b1, cfg_pkg::OFS_MODE, 32'h0000_0029);
    chk("ro err", 32'h0000_0000, err);
    apb(1'b0, cfg_pkg::OFS_MODE, 32'h0000_0000);
    chk("kept mode", 32'h0000_01A3, rd);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk("unmapped", 32'h0000_0001, err);
    fork
      u_ctrl.issue(cfg_pkg::CMD_LOAD, 13'h01A3, 1'b0);
      begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("busy", 32'h0000_0001, busy);
      end
    join
    @(negedge clk);
    chk("busy done", 32'h0000_0000, busy);
    conclude();
  end
endmodule
`default_nettype wire

// ===== hdl/cfg_pkg.sv
// Purpose: Shared constants for the memory mode configuration block.
// Assumes: Address bus of 13 bits, two bank-select inputs.
// Notes: Field positions, codes and APB offsets are named once here.
package cfg_pkg;
  localparam int ADDR_W = 13;
  localparam int BL_LSB = 0;
  localparam int BL_MSB = 2;
  localparam int ORDER_POS = 3;
  localparam int LAT_LSB = 4;
  localparam int LAT_MSB = 6;
  localparam int OPM_LSB = 7;
  localparam int OPM_MSB = 8;
  localparam int WB_POS = 9;
  localparam int RSV_LSB = 10;
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  localparam logic [2:0] LAT_2 = 3'h2;
  localparam logic [2:0] LAT_3 = 3'h3;
  localparam logic [1:0] OPM_STD = 2'h0;
  localparam logic [12:0] MODE_RESET = 13'h0000;
  localparam logic [11:0] OFS_MODE = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_WAIT = 12'h008;
  localparam int CFG_LOAD_WAIT_NS = 80;
  localparam int CLK_NS = 40;
  localparam int CFG_LOAD_WAIT_CYC = (CFG_LOAD_WAIT_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {
    CMD_OTHER = 2'b00,
    CMD_LOAD = 2'b01,
    CMD_READ = 2'b11,
    CMD_WRITE = 2'b10
  } cmd_t;
endpackage

// ===== hdl/mode_cfg.sv
// Purpose: Mode configuration register of a synchronous memory device.
// Assumes: Commands are synchronous to clk; APB shows the stored setup.
// Notes: Reserved codes are stored as given and flagged in status.
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module mode_cfg #(
  parameter int WAIT_CYC = cfg_pkg::CFG_LOAD_WAIT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Memory command side
  input wire logic [1:0] cmd,
  input wire logic [cfg_pkg::ADDR_W-1:0] addr,
  input wire logic bank_sel_bit0,
  input wire logic bank_sel_bit1,
  input wire logic banks_idle,
  // Decoded configuration, read timing and load status
  output logic [3:0] burst_len,
  output logic burst_order,
  output logic [2:0] read_latency,
  output logic write_burst_policy,
  output logic write_len_one,
  output logic read_drive,
  output logic read_valid,
  output logic load_busy,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  logic [cfg_pkg::ADDR_W-1:0] mode_reg;
  logic [3:0] err_reg;
  logic [7:0] wait_reg;
  logic [7:0] wait_next;
  logic load_now;
  logic read_now;
  logic [2:0] bl_code;
  logic [2:0] lat_code;
  logic order_bit;
  logic write_burst_bit;
  logic [1:0] opm_code;
  logic [2:0] lat_q;

  // Encodes a burst code as a beat count; zero marks full page or reserved.
  function automatic logic [3:0] bl_beats(input logic [2:0] code);
    unique case (code)
      cfg_pkg::BL_1: bl_beats = 4'h1;
      cfg_pkg::BL_2: bl_beats = 4'h2;
      cfg_pkg::BL_4: bl_beats = 4'h4;
      cfg_pkg::BL_8: bl_beats = 4'h8;
      default: bl_beats = 4'h0;
    endcase
  endfunction

  assign bl_code = mode_reg[cfg_pkg::BL_MSB:cfg_pkg::BL_LSB];
  assign order_bit = mode_reg[cfg_pkg::ORDER_POS];
  assign lat_code = mode_reg[cfg_pkg::LAT_MSB:cfg_pkg::LAT_LSB];
  assign opm_code = mode_reg[cfg_pkg::OPM_MSB:cfg_pkg::OPM_LSB];
  assign write_burst_bit = mode_reg[cfg_pkg::WB_POS];
  // Bank selects must be zero to target this register.
  assign load_now = (cmd == cfg_pkg::CMD_LOAD) && !bank_sel_bit0 && !bank_sel_bit1;
  assign read_now = (cmd == cfg_pkg::CMD_READ);

  // Only a load changes the stored word; there is no other writer.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      mode_reg <= cfg_pkg::MODE_RESET;
    else if (load_now)
      mode_reg <= addr;
  end

  // Error flags: reserved burst, reserved latency, reserved mode, misuse.
  // Misuse covers nonzero upper bits, load while busy, or banks not idle.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      err_reg <= 4'h0;
    else if (load_now)
    begin
      err_reg[0] <= (bl_beats(addr[2:0]) == 4'h0) && (addr[2:0] != cfg_pkg::BL_PAGE ||
                    addr[cfg_pkg::ORDER_POS]);
      err_reg[1] <= (addr[6:4] != cfg_pkg::LAT_2) && (addr[6:4] != cfg_pkg::LAT_3);
      err_reg[2] <= (addr[8:7] != cfg_pkg::OPM_STD);
      err_reg[3] <= (|addr[cfg_pkg::ADDR_W-1:cfg_pkg::RSV_LSB]) || !banks_idle ||
                    (wait_reg != 8'h00);
    end
  end

  always_comb
  begin
    wait_next = wait_reg;
    if (load_now)
      wait_next = 8'(WAIT_CYC);
    else if (wait_reg != 8'h00)
      wait_next = wait_reg - 8'h01;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      wait_reg <= 8'h00;
    else
      wait_reg <= wait_next;
  end

  // Decoded outputs are registered from the stored word; load_busy is registered from the next wait count.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      burst_len <= 4'h1;
      burst_order <= 1'b0;
      read_latency <= cfg_pkg::LAT_2;
      write_burst_policy <= 1'b0;
      write_len_one <= 1'b1;
      load_busy <= 1'b0;
    end
    else
    begin
      burst_len <= bl_beats(bl_code);
      // A single beat has nothing to order, so the bit is masked.
      burst_order <= (bl_code == cfg_pkg::BL_1) ? 1'b0 : order_bit;
      read_latency <= lat_code;
      write_burst_policy <= write_burst_bit;
      write_len_one <= write_burst_bit || (bl_code == cfg_pkg::BL_1);
      load_busy <= (wait_next != 8'h00);
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      lat_q <= cfg_pkg::LAT_2;
    else
      lat_q <= (lat_code == cfg_pkg::LAT_3) ? cfg_pkg::LAT_3 : cfg_pkg::LAT_2;
  end

  read_lat_pipe #(
    .DEPTH(3)
  ) u_pipe (
    .clk(clk),
    .resetn(resetn),
    .rd_start(read_now),
    .latency(lat_q),
    .drive_on(read_drive),
    .data_valid(read_valid)
  );

  // APB: zero wait states, read data registered in the setup cycle.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (paddr != cfg_pkg::OFS_MODE) &&
                 (paddr != cfg_pkg::OFS_STATUS) && (paddr != cfg_pkg::OFS_WAIT);
      if (psel && !penable && !pwrite)
      begin
        unique case (paddr)
          cfg_pkg::OFS_MODE: prdata <= {19'h0_0000, mode_reg};
          cfg_pkg::OFS_STATUS: prdata <= {27'h000_0000, load_busy, err_reg};
          cfg_pkg::OFS_WAIT: prdata <= {24'h00_0000, wait_reg};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  logic pwdata_unused;
  assign pwdata_unused = ^pwdata;

  // Properties.
  sequence load_seq;
    load_now ##1 1'b1;
  endsequence

  hold_no_load_a: assert property (@(posedge clk) disable iff (!resetn)
    !load_now |=> $stable(mode_reg)) else $error("mode changed without load");
  capture_addr_a: assert property (@(posedge clk) disable iff (!resetn)
    load_now |=> mode_reg == $past(addr)) else $error("load value not captured");
  bank_guard_a: assert property (@(posedge clk) disable iff (!resetn)
    (cmd == cfg_pkg::CMD_LOAD && bank_sel_bit0) |=> $stable(mode_reg))
    else $error("load with bank select taken");
  burst_len_a: assert property (@(posedge clk) disable iff (!resetn)
    load_seq ##1 (!load_now && $past(addr[2:0], 2) == cfg_pkg::BL_8) |-> burst_len == 4'h8)
    else $error("burst length decode wrong");
  order_mask_a: assert property (@(posedge clk) disable iff (!resetn)
    burst_len == 4'h1 |-> !burst_order) else $error("order not masked");
  write_single_a: assert property (@(posedge clk) disable iff (!resetn)
    write_burst_policy |-> write_len_one) else $error("write not single");
  wait_count_a: assert property (@(posedge clk) disable iff (!resetn)
    load_now |=> load_busy [*1] ##0 wait_reg == 8'(WAIT_CYC))
    else $error("load wait not started");
  lat_two_a: assert property (@(posedge clk) disable iff (!resetn)
    (read_now && lat_q == cfg_pkg::LAT_2) ##1 (lat_q == cfg_pkg::LAT_2) ##1
    (lat_q == cfg_pkg::LAT_2) |-> ##1 read_valid) else $error("latency two not met");
  lat_three_a: assert property (@(posedge clk) disable iff (!resetn)
    (read_now && lat_q == cfg_pkg::LAT_3) ##1 (lat_q == cfg_pkg::LAT_3) ##1
    (lat_q == cfg_pkg::LAT_3) ##1 (lat_q == cfg_pkg::LAT_3) |-> ##1 read_valid)
    else $error("latency three not met");
  reserved_flag_a: assert property (@(posedge clk) disable iff (!resetn)
    (load_now && addr[8:7] != cfg_pkg::OPM_STD) |=> err_reg[2])
    else $error("reserved mode not flagged");
endmodule
`default_nettype wire

// ===== hdl/read_lat_pipe.sv
// Purpose: Delays a read strobe by the programmed latency.
// Assumes: Latency is two or three clocks.
// Notes: Drive starts one edge before data is valid.
`timescale 1ns/1ps
`default_nettype none
module read_lat_pipe #(
  parameter int DEPTH = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control
  input wire logic rd_start,
  input wire logic [2:0] latency,
  // Result
  output logic drive_on,
  output logic data_valid
);
  logic [DEPTH-1:0] sr_reg;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      sr_reg <= '0;
    else
      sr_reg <= {sr_reg[DEPTH-2:0], rd_start};
  end
  // Stage k holds a read registered k+1 edges ago.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      drive_on <= 1'b0;
      data_valid <= 1'b0;
    end
    else
    begin
      // Drive rises after edge n+m-1 and valid after edge n+m, so neither may use rd_start.
      drive_on <= (latency == cfg_pkg::LAT_3) ? sr_reg[1] : sr_reg[0];
      data_valid <= (latency == cfg_pkg::LAT_3) ? sr_reg[2] : sr_reg[1];
    end
  end
endmodule
`default_nettype wire
